/* File: design/acr_regs.svh */
// Constants of the sample readout block: word size, cadence, settling.
// Assumes inclusion by bare name from the design files.
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// ****************************************************************
// Word format
// ****************************************************************
`define ACR_WORD_BITS 24

// ****************************************************************
// Cadence: conversion clocks per strobe for one unit of n
// ****************************************************************
`define ACR_PERIOD_BASE 8

// ****************************************************************
// Filter settling in conversion clocks, per decimation variant
// ****************************************************************
`define ACR_SETTLE_D8  12'h24e
`define ACR_SETTLE_D16 12'h49c
`define ACR_SETTLE_D32 12'h935

// ****************************************************************
// Idle levels of the sampled serial pins
// ****************************************************************
`define ACR_PIN_IDLE 4'h7

`endif

/* File: design/acr_pkg.sv */
// Types shared by the sample readout block.
// Assumes nothing beyond a SystemVerilog compiler.
package acr_pkg;

    // ****************************************************************
    // Conversion-side modes
    // ****************************************************************
    typedef enum logic [1:0] {
        ACR_POWERDOWN,
        ACR_SETTLING,
        ACR_RUNNING
    } acr_state_t;

    // Result word
    typedef logic [23:0] acr_word_t;

endpackage

/* File: design/acr_sync3.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes a synchronous active-low reset on the sampling clock.
`timescale 1ns/1ps
`default_nettype none

module acr_sync3 #(
    parameter int               WIDTH   = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Asynchronous levels in, filtered levels out
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] st1_reg;
    logic [WIDTH-1:0] st2_reg;
    logic [WIDTH-1:0] st3_reg;
    logic [WIDTH-1:0] lvl_reg;

    // Three flops; the first feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st1_reg <= RST_VAL;
            st2_reg <= RST_VAL;
            st3_reg <= RST_VAL;
        end else begin
            st1_reg <= pin_in;
            st2_reg <= st1_reg;
            st3_reg <= st2_reg;
        end
    end

    // A bit changes once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lvl_reg <= RST_VAL;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (st2_reg[i] == st3_reg[i]) begin
                    lvl_reg[i] <= st3_reg[i];
                end
            end
        end
    end

    assign level_out = lvl_reg;

endmodule

`default_nettype wire

/* File: design/acr_readout.sv */
// Sample cadence and serial readout of an oversampled 24-bit converter.
// Assumes conv_clk and the serial pins come from the host; sample_word is
// produced by the converter core on conv_clk.
`timescale 1ns/1ps
`default_nettype none
`include "acr_regs.svh"

// Contract
// - One ready strobe period lasts n times 8 conversion clocks, n 1, 2 or 4.
// - No settled result is reported until 590, 1180 or 2357 clocks pass.
// - Each period is a high pulse then a low window in which the host reads.
// - The ready strobe falls on a rising conversion clock edge.
// - The data output driver turns on when chip select falls.
// - The data output driver turns off after chip select rises.
// - Each serial clock falling edge moves the output to the next bit.
// - With chip select held low, data is valid through the low window.
// - Daisy-chain input bits are captured on serial clock falling edges.
// - Sync/power-down low at a clock edge enters the mode, strobe high.
// - Sync/power-down high at a clock edge leaves the mode and resumes.
// - Each result leaves as a 24-bit two's complement word, MSB first.
module acr_readout
    import acr_pkg::*;
#(
    parameter int DECIM_N = 1
) (
    // System clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Conversion clock and converter core
    input  wire logic       conv_clk,
    input  wire acr_pkg::acr_word_t sample_word,
    // Sync and power-down pin
    input  wire logic       sync_powerdown_n,
    // Ready strobe
    output logic            sample_ready_n,
    // Serial port
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       sdi,
    output logic            sdo,
    output logic            sdo_oe
);
    import acr_pkg::*;

    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam int         PERIOD    = `ACR_PERIOD_BASE * DECIM_N;
    localparam logic [4:0] PERIOD_M1 = 5'(PERIOD - 1);
    localparam int         WB        = `ACR_WORD_BITS;

    // Settling length for the chosen variant
    function automatic logic [11:0] acr_settle(input int n);
        logic [11:0] cyc;
        case (n)
            1: cyc = `ACR_SETTLE_D8;
            2: cyc = `ACR_SETTLE_D16;
            default: cyc = `ACR_SETTLE_D32;
        endcase
        return cyc;
    endfunction

    localparam logic [11:0] SETTLE_M1 = acr_settle(DECIM_N) - 12'h001;

    // ****************************************************************
    // Conversion clock domain
    // ****************************************************************
    logic       crst1_reg;
    logic       crst2_reg;
    acr_state_t state_reg;
    acr_state_t state_next;
    logic [4:0] phase_reg;
    logic [4:0] phase_next;
    logic [11:0] settle_reg;
    logic [11:0] settle_next;
    logic       rdy_n_reg;
    acr_word_t  word_reg;
    logic       tgl_reg;
    logic       launch;
    logic       rdy_rise;

    // Reset carried into the conversion domain
    always_ff @(posedge conv_clk) begin
        crst1_reg <= rst_n;
        crst2_reg <= crst1_reg;
    end

    // Mode, phase and settling counters, next values
    always_comb begin
        state_next  = state_reg;
        phase_next  = (phase_reg == PERIOD_M1) ? 5'h00 : phase_reg + 5'h01;
        settle_next = settle_reg;
        case (state_reg)
            ACR_POWERDOWN: begin
                phase_next  = 5'h00;
                settle_next = 12'h000;
                state_next  = ACR_SETTLING;
            end
            ACR_SETTLING: begin
                settle_next = settle_reg + 12'h001;
                if (settle_reg == SETTLE_M1) begin
                    state_next = ACR_RUNNING;
                end
            end
            ACR_RUNNING: begin
                settle_next = settle_reg;
            end
            default: begin
                state_next = ACR_POWERDOWN;
            end
        endcase
        if (!sync_powerdown_n) begin
            state_next  = ACR_POWERDOWN;
            phase_next  = 5'h00;
            settle_next = 12'h000;
        end
    end

    // New result is released where the strobe falls
    assign launch = (state_next == ACR_RUNNING) && (phase_next == 5'h01);

    // Mode and counters
    always_ff @(posedge conv_clk) begin
        if (!crst2_reg) begin
            state_reg  <= ACR_POWERDOWN;
            phase_reg  <= 5'h00;
            settle_reg <= 12'h000;
        end else begin
            state_reg  <= state_next;
            phase_reg  <= phase_next;
            settle_reg <= settle_next;
        end
    end

    // Strobe goes high at phase zero or when leaving the running mode
    assign rdy_rise = (state_next != ACR_RUNNING) || (phase_next == 5'h00);

    // Strobe: high one clock at phase zero, low until the next phase zero
    always_ff @(posedge conv_clk) begin
        if (!crst2_reg) begin
            rdy_n_reg <= 1'b1;
        end else if (launch) begin
            rdy_n_reg <= 1'b0;
        end else if (rdy_rise) begin
            rdy_n_reg <= 1'b1;
        end
    end

    // Result capture and hand-over toggle
    always_ff @(posedge conv_clk) begin
        if (!crst2_reg) begin
            word_reg <= '0;
            tgl_reg  <= 1'b0;
        end else if (launch) begin
            word_reg <= sample_word;
            tgl_reg  <= !tgl_reg;
        end
    end

    assign sample_ready_n = rdy_n_reg;

    // ****************************************************************
    // System clock domain: serial port
    // ****************************************************************
    logic [3:0] pin_lvl;
    logic       sclk_s;
    logic       cs_n_s;
    logic       sdi_s;
    logic       tgl_s;
    logic       sclk_prev_reg;
    logic       tgl_prev_reg;
    logic       sclk_fall;
    logic       word_new;
    acr_word_t  sh_reg;
    acr_word_t  sh_next;
    logic       sdo_reg;
    logic       oe_reg;

    // Pins and the hand-over toggle through the synchroniser
    acr_sync3 #(
        .WIDTH   (4),
        .RST_VAL (`ACR_PIN_IDLE)
    ) u_sync (
        .clk       (sys_clk),
        .rst_n     (rst_n),
        .pin_in    ({tgl_reg, sdi, cs_n, sclk}),
        .level_out (pin_lvl)
    );

    assign sclk_s = pin_lvl[0];
    assign cs_n_s = pin_lvl[1];
    assign sdi_s  = pin_lvl[2];
    assign tgl_s  = pin_lvl[3];

    // Edge detection on filtered levels
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sclk_prev_reg <= 1'b1;
            tgl_prev_reg  <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_s;
            tgl_prev_reg  <= tgl_s;
        end
    end

    assign sclk_fall = sclk_prev_reg && !sclk_s;
    assign word_new  = tgl_s ^ tgl_prev_reg;

    // Shift register: load on new word, shift in chain bits on falls
    always_comb begin
        sh_next = sh_reg;
        if (word_new) begin
            sh_next = word_reg;
        end else if (sclk_fall && !cs_n_s) begin
            sh_next = {sh_reg[WB-2:0], sdi_s};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sh_reg <= '0;
        end else begin
            sh_reg <= sh_next;
        end
    end

    // Output bit and driver enable
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sdo_reg <= 1'b0;
            oe_reg  <= 1'b0;
        end else begin
            sdo_reg <= sh_next[WB-1];
            oe_reg  <= !cs_n_s;
        end
    end

    assign sdo    = sdo_reg;
    assign sdo_oe = oe_reg;

    // ****************************************************************
    // Checks: conversion domain
    // ****************************************************************
    localparam int SETTLE_INT = int'(SETTLE_M1) + 1;
    logic [5:0]  gap_reg;
    logic        gap_ok_reg;
    logic [11:0] exit_reg;

    // Cycles since last fall and since leaving power-down
    always_ff @(posedge conv_clk) begin
        if (!crst2_reg || !sync_powerdown_n) begin
            gap_reg    <= 6'h00;
            gap_ok_reg <= 1'b0;
            exit_reg   <= 12'h000;
        end else begin
            gap_reg  <= launch ? 6'h01 : gap_reg + 6'h01;
            gap_ok_reg <= gap_ok_reg || launch;
            exit_reg <= (exit_reg == 12'hfff) ? exit_reg : exit_reg + 12'h001;
        end
    end

    a_high_one_cycle: assert property (@(posedge conv_clk)
        disable iff (!crst2_reg)
        $rose(sample_ready_n) && state_reg == ACR_RUNNING && sync_powerdown_n
        |=> !sample_ready_n || !sync_powerdown_n)
        else $error("ready pulse not one clock wide");

    a_strobe_period: assert property (@(posedge conv_clk)
        disable iff (!crst2_reg)
        $fell(sample_ready_n) && $past(gap_ok_reg) && gap_ok_reg
        |-> $past(gap_reg) == 6'(PERIOD))
        else $error("ready period wrong");

    a_settle_wait: assert property (@(posedge conv_clk)
        disable iff (!crst2_reg)
        $fell(sample_ready_n) |-> int'(exit_reg) >= SETTLE_INT)
        else $error("result reported before settling");

    a_pd_high: assert property (@(posedge conv_clk)
        disable iff (!crst2_reg)
        !sync_powerdown_n |=> sample_ready_n && state_reg == ACR_POWERDOWN)
        else $error("strobe not high in power-down");

    a_pd_restart: assert property (@(posedge conv_clk)
        disable iff (!crst2_reg)
        !sync_powerdown_n ##1 sync_powerdown_n
        |=> state_reg == ACR_SETTLING && phase_reg == 5'h00
            && settle_reg == 12'h000)
        else $error("filter not restarted on exit");

    a_fall_launch: assert property (@(posedge conv_clk)
        disable iff (!crst2_reg)
        $fell(sample_ready_n) |-> phase_reg == 5'h01 && $changed(tgl_reg))
        else $error("strobe fell without a new result");

    c_strobe_fall: cover property (@(posedge conv_clk)
        disable iff (!crst2_reg) $fell(sample_ready_n));

    c_pd_exit: cover property (@(posedge conv_clk)
        disable iff (!crst2_reg) $rose(sync_powerdown_n));

    // ****************************************************************
    // Checks: system domain
    // ****************************************************************
    a_oe_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(cs_n_s) |=> sdo_oe)
        else $error("driver not enabled after select");

    a_oe_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(cs_n_s) |=> !sdo_oe ##1 !sdo_oe)
        else $error("driver not released after select");

    a_shift_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sclk_fall && !cs_n_s && !word_new |=> sdo == $past(sh_reg[WB-2]))
        else $error("output did not advance on fall");

    a_word_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        word_new |=> sdo == word_reg[WB-1])
        else $error("new word MSB not presented");

    c_read_bit: cover property (@(posedge sys_clk)
        disable iff (!rst_n) sclk_fall && !cs_n_s);

    c_cs_release: cover property (@(posedge sys_clk)
        disable iff (!rst_n) $rose(cs_n_s) ##1 !sdo_oe);

endmodule

`default_nettype wire

/* File: sim/acr_host_model.sv */
// Host controller model: makes the conversion clock, reads each sample.
// Assumes one device on the serial pins; results go to the bench.
`timescale 1ns/1ps
`default_nettype none

module acr_host_model (
    // Clocks
    input  wire logic        sys_clk,
    output logic             conv_clk,
    // Device pins
    input  wire logic        sample_ready_n,
    input  wire logic        sdo,
    input  wire logic        sdo_oe,
    output logic             sclk,
    output logic             cs_n,
    output logic             sdi,
    // Bench control and results
    input  wire logic        framed,
    input  wire logic [7:0]  tx_bits,
    output logic [31:0]      rx_bits,
    output logic [2:0]       oe_seen,
    output int               rd_count
);
    logic line_last = 1'b0;
    logic sd_line;

    // Released line shows the inverse of the last driven value
    assign sd_line = sdo_oe ? sdo : ~line_last;
    always @(posedge sys_clk) begin
        if (sdo_oe)
            line_last <= sdo;
    end

    // Conversion clock, short high time, own phase
    initial begin
        conv_clk = 1'b0;
        #3.3;
        forever begin
            conv_clk = 1'b1;
            #40;
            conv_clk = 1'b0;
            #120;
        end
    end

    // One read of 32 bits after each ready strobe fall
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdi = 1'b1;
        rx_bits = '0;
        oe_seen = '0;
        rd_count = 0;
        forever begin
            @(negedge sample_ready_n);
            repeat (9) @(negedge sys_clk);
            oe_seen[0] = sdo_oe;
            cs_n = 1'b0;
            repeat (8) @(negedge sys_clk);
            oe_seen[1] = sdo_oe;
            for (int b = 0; b < 32; b++) begin
                sdi = (b < 8) ? tx_bits[7-b] : ~sdi;
                repeat (6) @(negedge sys_clk);
                rx_bits[31-b] = sd_line;
                sclk = 1'b0;
                repeat (6) @(negedge sys_clk);
                sclk = 1'b1;
            end
            // Done well inside the low window
            if (framed) cs_n = 1'b1;
            repeat (8) @(negedge sys_clk);
            oe_seen[2] = sdo_oe;
            rd_count++;
        end
    end
endmodule

`default_nettype wire

/* File: sim/test_adc_sample_serial_readout.sv */
// Bench: three rate variants on one host; serial reads on the slowest.
// Assumes the host model drives the conversion clock and serial pins.
`timescale 1ns/1ps
`default_nettype none
`include "acr_regs.svh"

module test_adc_sample_serial_readout;
    import acr_pkg::*;

    logic        sys_clk;
    logic        rst_n;
    logic        sync_powerdown_n;
    logic        conv_clk;
    logic        sclk;
    logic        cs_n;
    logic        sdi;
    logic        framed;
    logic        prev_framed;
    logic        pd_act;
    acr_word_t   sample_word;
    acr_word_t   last_word;
    acr_word_t   vw [2];
    logic        vq [2];
    logic [2:0]  rdy;
    logic [2:0]  rdy_prev;
    logic [2:0]  sdo_v;
    logic [2:0]  oe_v;
    logic [2:0]  first;
    logic [7:0]  tx_bits;
    logic [31:0] rx_bits;
    logic [2:0]  oe_seen;
    int          rd_count;
    int          errors;
    int          checks_done;
    int          cycles;
    int          pd_lows;
    int          cnt [3];
    int          hi [3];

    // ****************************************************************
    // Devices and host
    // ****************************************************************
    for (genvar i = 0; i < 3; i++) begin : g_dut
        acr_readout #(.DECIM_N(1 << i)) dut_u (
            .sys_clk          (sys_clk),
            .rst_n            (rst_n),
            .conv_clk         (conv_clk),
            .sample_word      (sample_word),
            .sync_powerdown_n (sync_powerdown_n),
            .sample_ready_n   (rdy[i]),
            .sclk             (sclk),
            .cs_n             (cs_n),
            .sdi              (sdi),
            .sdo              (sdo_v[i]),
            .sdo_oe           (oe_v[i])
        );
    end

    acr_host_model host_u (
        .sys_clk        (sys_clk),
        .conv_clk       (conv_clk),
        .sample_ready_n (rdy[2]),
        .sdo            (sdo_v[2]),
        .sdo_oe         (oe_v[2]),
        .sclk           (sclk),
        .cs_n           (cs_n),
        .sdi            (sdi),
        .framed         (framed),
        .tx_bits        (tx_bits),
        .rx_bits        (rx_bits),
        .oe_seen        (oe_seen),
        .rd_count       (rd_count)
    );

    // Faster variants: new word MSB shows while the host is not reading
    for (genvar v = 0; v < 2; v++) begin : g_msb
        always @(negedge rdy[v]) begin
            vw[v] = sample_word;
            vq[v] = cs_n;
            repeat (10) @(negedge sys_clk);
            if (vq[v] === 1'b1 && cs_n === 1'b1)
                check("word msb", 32'(vw[v][23]), 32'(sdo_v[v]));
        end
    end

    // ****************************************************************
    // Expectations, checks, verdict
    // ****************************************************************
    function automatic int settle_of(input int i);
        case (i)
            0: return `ACR_SETTLE_D8;
            1: return `ACR_SETTLE_D16;
            default: return `ACR_SETTLE_D32;
        endcase
    endfunction

    function automatic int period_of(input int i);
        return `ACR_PERIOD_BASE * (1 << i);
    endfunction

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Clock and hang guard
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 95000) begin
            errors++;
            $display("Error timeout expected done seen hang");
            stop_test();
        end
    end

    // Converter core results and power-down tracking
    always @(negedge conv_clk) sample_word <= acr_word_t'($urandom);
    always @(posedge conv_clk) pd_act <= !sync_powerdown_n;

    // Strobe cadence, width and settling per variant
    always @(negedge conv_clk) begin
        for (int i = 0; i < 3; i++) begin
            cnt[i]++;
            if (rdy[i] === 1'b1) hi[i]++;
            if (pd_act && rdy[i] !== 1'b1) pd_lows++;
            if (rdy_prev[i] === 1'b1 && rdy[i] === 1'b0) begin
                if (first[i])
                    check("settle", 1, cnt[i] >= settle_of(i) &&
                          cnt[i] <= settle_of(i) + period_of(i) + 8);
                else begin
                    check("period", period_of(i), cnt[i]);
                    check("high width", 1, hi[i]);
                end
                first[i] = 1'b0;
                cnt[i] = 0;
                hi[i] = 0;
            end
            if (!rst_n || pd_act) begin
                first[i] = 1'b1;
                cnt[i] = 0;
            end
            rdy_prev[i] = rdy[i];
        end
    end

    // Word latched at the fall, fall on a rising clock edge
    always @(negedge rdy[2]) begin
        last_word = sample_word;
        check("fall edge", 1, conv_clk);
    end

    // Wait for reads and compare each one
    task automatic do_reads(input int k);
        int n0;
        for (int j = 0; j < k; j++) begin
            n0 = rd_count;
            wait (rd_count != n0);
            check("own word", {8'h00, last_word}, {8'h00, rx_bits[31:8]});
            check("chained bits", {24'h0, tx_bits}, {24'h0, rx_bits[7:0]});
            check("oe before", {31'h0, !prev_framed}, {31'h0, oe_seen[0]});
            check("oe during", 1, {31'h0, oe_seen[1]});
            check("oe after", {31'h0, !framed}, {31'h0, oe_seen[2]});
            check("oe all", 32'({3{oe_v[2]}}), 32'(oe_v));
            @(negedge sys_clk);
            prev_framed = framed;
            framed = (j < 4) ? (j != 1 && j != 2) : 1'($urandom);
            tx_bits = (j == 0) ? 8'h00 : 8'($urandom);
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        sync_powerdown_n = 1'b1;
        framed = 1'b1;
        prev_framed = 1'b1;
        pd_act = 1'b0;
        tx_bits = 8'hff;
        sample_word = '0;
        last_word = '0;
        rdy_prev = 3'h7;
        first = 3'h7;
        errors = 0;
        checks_done = 0;
        cycles = 0;
        pd_lows = 0;
        for (int i = 0; i < 3; i++) begin
            cnt[i] = 0;
            hi[i] = 0;
        end
        void'($urandom(23226));
        // Reset long enough for the conversion domain too
        repeat (10) @(negedge conv_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        do_reads(8);
        $display("test cadence and readout done");
        @(negedge conv_clk);
        sync_powerdown_n = 1'b0;
        repeat (40) @(negedge conv_clk);
        check("strobe low in power-down", 0, pd_lows);
        sync_powerdown_n = 1'b1;
        do_reads(3);
        for (int i = 0; i < 3; i++) check("resumed", 0, {31'h0, first[i]});
        $display("test power-down and resync done");
        stop_test();
    end
endmodule

`default_nettype wire
